// ===== icc_capture_top.sv
// eight-channel input capture bank with per-channel four-word timestamp fifos
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module icc_capture_top (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       srst_i,
    // register port
    input  wire logic [icc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [icc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [icc_pkg::DATA_W-1:0] rdata_o,
    // capture inputs and time bases
    input  wire logic [icc_pkg::NUM_CH-1:0] capture_pin_i,
    input  wire logic [icc_pkg::DATA_W-1:0] timer2_count_i,
    input  wire logic [icc_pkg::DATA_W-1:0] timer3_count_i,
    // power state
    input  wire logic                       sleep_i,
    input  wire logic                       idle_i,
    // interrupt and wake
    output logic                            irq_o,
    output logic                            wake_o
);

    localparam int N = icc_pkg::NUM_CH;

    // ********************
    // storage
    // ********************
    logic [icc_pkg::DATA_W-1:0] fifo                       [N][icc_pkg::DEPTH];
    logic [icc_pkg::CNT_W-1:0]  fill                       [N];
    logic [2:0]                 capture_mode_field         [N];
    logic [1:0]                 interrupt_event_count      [N];
    logic [1:0]                 event_tally                [N];
    logic [3:0]                 prescale                   [N];
    logic [N-1:0]               capture_timer_select;
    logic [N-1:0]               stop_in_idle_bit;
    logic [N-1:0]               capture_overflow_flag;
    logic [N-1:0]               lock;
    logic [N-1:0]               pin_prev;
    logic [N-1:0]               interrupt_flag_register;
    logic [N-1:0]               capture_channel_irq_enable;

    // ********************
    // per-channel event decode
    // ********************
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] edge_hit;
    logic [N-1:0] capture_ev;
    logic [N-1:0] int_only_hit;
    logic [N-1:0] store;
    logic [N-1:0] ovf_set;
    logic [N-1:0] flag_set;
    logic [N-1:0] pop;
    logic [N-1:0] ctrl_wr;
    logic [N-1:0] capture_buffer_not_empty;
    logic [N-1:0] next_wake;
    logic         flag_rd;

    function automatic logic mode_edge(input logic [2:0] mode, input logic r, input logic f);
        case (mode)
            icc_pkg::MODE_EVERY_EDGE: mode_edge = r | f;
            icc_pkg::MODE_FALL:       mode_edge = f;
            icc_pkg::MODE_RISE,
            icc_pkg::MODE_RISE4,
            icc_pkg::MODE_RISE16,
            icc_pkg::MODE_INT_ONLY:   mode_edge = r;
            default:                  mode_edge = 1'b0;
        endcase
    endfunction

    function automatic logic prescale_ok(input logic [2:0] mode, input logic [3:0] cnt);
        case (mode)
            icc_pkg::MODE_RISE4:  prescale_ok = (cnt[1:0] == icc_pkg::PRE4_LAST[1:0]);
            icc_pkg::MODE_RISE16: prescale_ok = (cnt == icc_pkg::PRE16_LAST);
            default:              prescale_ok = 1'b1;
        endcase
    endfunction

    assign flag_rd = rd_i && (addr_i == icc_pkg::ADDR_FLAG);

    always_comb begin
        for (int c = 0; c < N; c++) begin
            rise[c]     = capture_pin_i[c] & ~pin_prev[c];
            fall[c]     = ~capture_pin_i[c] & pin_prev[c];
            edge_hit[c] = mode_edge(capture_mode_field[c], rise[c], fall[c]);
            // sleep or idle in mode 111: interrupt source only
            int_only_hit[c] = (sleep_i || idle_i) && rise[c]
                              && (capture_mode_field[c] == icc_pkg::MODE_INT_ONLY);
            // idle keeps full capture unless stop-in-idle is set
            capture_ev[c] = edge_hit[c] && !sleep_i && !(idle_i && stop_in_idle_bit[c])
                            && !int_only_hit[c]
                            && prescale_ok(capture_mode_field[c], prescale[c]);
            // locked channel drops events until emptied
            store[c]   = capture_ev[c] && !lock[c] && (fill[c] < icc_pkg::FIFO_FULL);
            // full buffer raises overflow except in mode 001
            ovf_set[c] = capture_ev[c] && !lock[c] && (fill[c] == icc_pkg::FIFO_FULL)
                         && (capture_mode_field[c] != icc_pkg::MODE_EVERY_EDGE);
            // flag per edge in 001, else after counted events
            flag_set[c] = int_only_hit[c]
                          || (capture_ev[c]
                              && (capture_mode_field[c] == icc_pkg::MODE_EVERY_EDGE))
                          || (store[c] && (event_tally[c] == interrupt_event_count[c]));
            // wake regardless of timer state when enabled
            next_wake[c] = int_only_hit[c] && capture_channel_irq_enable[c];
            pop[c]     = rd_i && (addr_i == (icc_pkg::ADDR_BUF_BASE | 6'(c)));
            ctrl_wr[c] = wr_i && (addr_i == (icc_pkg::ADDR_CTRL_BASE | 6'(c)));
            // not empty while any word is held
            capture_buffer_not_empty[c] = (fill[c] != 3'h0);
        end
    end

    // ********************
    // edge history and prescalers
    // ********************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= capture_pin_i;
        end
    end

    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i || ctrl_wr[c]) begin
                prescale[c] <= 4'h0;
            end else if (edge_hit[c] && !sleep_i && !(idle_i && stop_in_idle_bit[c])) begin
                prescale[c] <= prescale[c] + 4'h1;
            end
        end
    end

    // ********************
    // control registers
    // ********************
    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i) begin
                capture_mode_field[c]    <= icc_pkg::MODE_RESET;
                interrupt_event_count[c] <= icc_pkg::ICI_RESET;
                capture_timer_select[c]  <= icc_pkg::TMR_SEL_RESET;
                stop_in_idle_bit[c]      <= 1'b0;
            end else if (ctrl_wr[c]) begin
                capture_mode_field[c]    <= wdata_i[icc_pkg::CTRL_MODE_HI:0];
                interrupt_event_count[c] <= wdata_i[icc_pkg::CTRL_ICI_HI:icc_pkg::CTRL_ICI_LO];
                capture_timer_select[c]  <= wdata_i[icc_pkg::CTRL_TMR_BIT];
                stop_in_idle_bit[c]      <= wdata_i[icc_pkg::CTRL_SIDL_BIT];
            end
        end
    end

    // ********************
    // overflow, lock and event tally
    // ********************
    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i) begin
                capture_overflow_flag[c] <= 1'b0;
            end else if (ovf_set[c]) begin
                capture_overflow_flag[c] <= 1'b1;
            end else if (ctrl_wr[c] && !wdata_i[icc_pkg::CTRL_OV_BIT]) begin
                capture_overflow_flag[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i) begin
                lock[c] <= 1'b0;
            end else if (ovf_set[c]) begin
                lock[c] <= 1'b1;
            end else if (fill[c] == 3'h0) begin
                lock[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i || ctrl_wr[c]) begin
                event_tally[c] <= 2'h0;
            end else if (store[c] && capture_mode_field[c] != icc_pkg::MODE_EVERY_EDGE) begin
                event_tally[c] <= (event_tally[c] == interrupt_event_count[c])
                                  ? 2'h0 : event_tally[c] + 2'h1;
            end
        end
    end

    // ********************
    // capture fifos
    // ********************
    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i) begin
                fill[c] <= 3'h0;
            end else begin
                fill[c] <= fill[c] + {2'h0, store[c]}
                           - {2'h0, pop[c] && capture_buffer_not_empty[c]};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        for (int c = 0; c < N; c++) begin
            if (srst_i) begin
                for (int i = 0; i < icc_pkg::DEPTH; i++) begin
                    fifo[c][i] <= '0;
                end
            end else begin
                // oldest word out, remainder shifts toward head
                if (pop[c] && capture_buffer_not_empty[c]) begin
                    for (int i = 0; i < icc_pkg::DEPTH - 1; i++) begin
                        fifo[c][i] <= fifo[c][i+1];
                    end
                end
                if (store[c]) begin
                    fifo[c][(pop[c] && capture_buffer_not_empty[c]) ? fill[c][1:0] - 2'h1
                                                                    : fill[c][1:0]]
                        <= capture_timer_select[c] ? timer3_count_i : timer2_count_i;
                end
            end
        end
    end

    // ********************
    // interrupt flags, enables, wake
    // ********************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            interrupt_flag_register <= '0;
        end else begin
            // set wins over clear-on-read
            interrupt_flag_register <= (flag_rd ? '0 : interrupt_flag_register) | flag_set;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            capture_channel_irq_enable <= '0;
        end else if (wr_i && addr_i == icc_pkg::ADDR_ENABLE) begin
            capture_channel_irq_enable <= wdata_i[N-1:0];
        end
    end

    assign irq_o = |(interrupt_flag_register & capture_channel_irq_enable);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= |next_wake;
        end
    end

    // ********************
    // read data
    // ********************
    always_ff @(posedge clock_i) begin
        if (srst_i || !rd_i) begin
            rdata_o <= '0;
        end else if (addr_i == icc_pkg::ADDR_FLAG) begin
            rdata_o <= {8'h00, interrupt_flag_register};
        end else if (addr_i == icc_pkg::ADDR_ENABLE) begin
            rdata_o <= {8'h00, capture_channel_irq_enable};
        end else if (addr_i[5:3] == icc_pkg::ADDR_BUF_BASE[5:3]) begin
            rdata_o <= fifo[addr_i[2:0]][0];
        end else if (addr_i[5:3] == icc_pkg::ADDR_CTRL_BASE[5:3]) begin
            rdata_o <= {2'h0, stop_in_idle_bit[addr_i[2:0]], 5'h00,
                        capture_timer_select[addr_i[2:0]],
                        interrupt_event_count[addr_i[2:0]],
                        capture_overflow_flag[addr_i[2:0]],
                        capture_buffer_not_empty[addr_i[2:0]],
                        capture_mode_field[addr_i[2:0]]};
        end else begin
            rdata_o <= '0;
        end
    end

    // ********************
    // checks
    // ********************
    property p_fill_max;
        @(posedge clock_i) disable iff (srst_i) fill[0] <= icc_pkg::FIFO_FULL;
    endproperty
    a_fill_max: assert property (p_fill_max) else $error("fifo fill above four");

    property p_bne_first;
        @(posedge clock_i) disable iff (srst_i)
            (store[0] && fill[0] == 3'h0) |=> capture_buffer_not_empty[0];
    endproperty
    a_bne_first: assert property (p_bne_first) else $error("not-empty missing");

    property p_shift;
        @(posedge clock_i) disable iff (srst_i)
            (pop[0] && fill[0] >= 3'h2) |=> fifo[0][0] == $past(fifo[0][1]);
    endproperty
    a_shift: assert property (p_shift) else $error("fifo did not shift");

    property p_overflow;
        @(posedge clock_i) disable iff (srst_i)
            ovf_set[0] |=> capture_overflow_flag[0] && fill[0] == $past(fill[0]) - {2'h0, $past(pop[0])};
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow mishandled");

    property p_lock;
        @(posedge clock_i) disable iff (srst_i) (lock[0] && fill[0] != 3'h0) |-> !store[0];
    endproperty
    a_lock: assert property (p_lock) else $error("capture while locked");

    property p_every_edge;
        @(posedge clock_i) disable iff (srst_i)
            (capture_ev[0] && capture_mode_field[0] == icc_pkg::MODE_EVERY_EDGE && !flag_rd)
            |=> interrupt_flag_register[0];
    endproperty
    a_every_edge: assert property (p_every_edge) else $error("edge flag missing");

    property p_no_ovf_001;
        @(posedge clock_i) disable iff (srst_i)
            (capture_mode_field[0] == icc_pkg::MODE_EVERY_EDGE && !capture_overflow_flag[0])
            |=> !capture_overflow_flag[0];
    endproperty
    a_no_ovf_001: assert property (p_no_ovf_001) else $error("overflow in mode 001");

    property p_wake;
        @(posedge clock_i) disable iff (srst_i)
            (sleep_i && rise[0] && capture_channel_irq_enable[0]
             && capture_mode_field[0] == icc_pkg::MODE_INT_ONLY) |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing");

    property p_sleep_nostore;
        @(posedge clock_i) disable iff (srst_i)
            $past(sleep_i) |-> fill[0] <= $past(fill[0]) || $past(srst_i);
    endproperty
    a_sleep_nostore: assert property (p_sleep_nostore) else $error("store in sleep");

    property p_stamp;
        @(posedge clock_i) disable iff (srst_i)
            (store[0] && fill[0] == 3'h0 && capture_timer_select[0])
            |=> fifo[0][0] == $past(timer3_count_i);
    endproperty
    a_stamp: assert property (p_stamp) else $error("wrong timestamp");

    property p_irq;
        @(posedge clock_i) disable iff (srst_i)
            (flag_set[0] && capture_channel_irq_enable[0]
             && !(wr_i && addr_i == icc_pkg::ADDR_ENABLE)) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing for enabled flag");

endmodule

// ===== icc_pin_model.sv
// far-side model: external digital signals on the capture pins
`timescale 1ns/100ps
module icc_pin_model (
    // clock
    input  wire logic                       clock_i,
    // capture pins
    output logic      [icc_pkg::NUM_CH-1:0] pin_o
);
    initial pin_o = '0;

    // level moves only just after an edge, at most once per clock
    task automatic set_level(input int ch, input logic lvl);
        @(posedge clock_i);
        pin_o[ch] <= lvl;
    endtask
endmodule

// ===== icc_pkg.sv
// constants shared by the input capture channel bank
package icc_pkg;

    // ********************
    // sizes
    // ********************
    localparam int          NUM_CH       = 8;
    localparam int          DEPTH        = 4;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 6;
    localparam int          CNT_W        = 3;

    // ********************
    // register offsets (word index on the register port)
    // ********************
    localparam logic [5:0]  ADDR_CTRL_BASE = 6'h00;
    localparam logic [5:0]  ADDR_BUF_BASE  = 6'h08;
    localparam logic [5:0]  ADDR_FLAG      = 6'h10;
    localparam logic [5:0]  ADDR_ENABLE    = 6'h11;

    // ********************
    // control register fields
    // ********************
    localparam int          CTRL_SIDL_BIT = 13;
    localparam int          CTRL_TMR_BIT  = 7;
    localparam int          CTRL_ICI_HI   = 6;
    localparam int          CTRL_ICI_LO   = 5;
    localparam int          CTRL_OV_BIT   = 4;
    localparam int          CTRL_BNE_BIT  = 3;
    localparam int          CTRL_MODE_HI  = 2;

    // ********************
    // capture modes
    // ********************
    localparam logic [2:0]  MODE_OFF        = 3'h0;
    localparam logic [2:0]  MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0]  MODE_FALL       = 3'h2;
    localparam logic [2:0]  MODE_RISE       = 3'h3;
    localparam logic [2:0]  MODE_RISE4      = 3'h4;
    localparam logic [2:0]  MODE_RISE16     = 3'h5;
    localparam logic [2:0]  MODE_INT_ONLY   = 3'h7;

    // ********************
    // counts and reset values
    // ********************
    localparam logic [3:0]  PRE4_LAST       = 4'h3;
    localparam logic [3:0]  PRE16_LAST      = 4'hF;
    localparam logic [2:0]  FIFO_FULL       = 3'h4;
    localparam logic        TMR_SEL_RESET   = 1'h1;
    localparam logic [2:0]  MODE_RESET      = 3'h0;
    localparam logic [1:0]  ICI_RESET       = 2'h0;

endpackage

// ===== tb_top.sv
// self-checking bench for the input capture bank
`timescale 1ns/100ps
module tb_top;
    localparam logic [5:0] A_CTL = icc_pkg::ADDR_CTRL_BASE;
    localparam logic [5:0] A_BUF = icc_pkg::ADDR_BUF_BASE;
    localparam logic [5:0] A_FLG = icc_pkg::ADDR_FLAG;
    localparam logic [5:0] A_ENA = icc_pkg::ADDR_ENABLE;
    logic        clock_i;
    logic        srst_i;
    logic [5:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic [7:0]  pin;
    logic [15:0] t2;
    logic [15:0] t3;
    logic        sleep_i;
    logic        idle_i;
    logic        irq_o;
    logic        wake_o;
    logic [31:0] rng;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] l2;
    logic [15:0] l3;
    logic [2:0]  md;
    logic [15:0] q[$];
    int          error_cnt;
    int          check_count;
    int          cycles;
    int          wakes;
    int          ch;

    icc_capture_top DUT (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .capture_pin_i(pin), .timer2_count_i(t2), .timer3_count_i(t3),
        .sleep_i(sleep_i), .idle_i(idle_i), .irq_o(irq_o), .wake_o(wake_o));
    icc_pin_model pins (.clock_i(clock_i), .pin_o(pin));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // wake pulses and the hang limit
    always @(posedge clock_i) begin
        cycles++;
        if (wake_o === 1'b1) wakes++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [15:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction

    // control word: timer select, event count, {overflow, not-empty}, mode
    function automatic logic [15:0] cw(input logic ts, input logic [1:0] ici,
                                       input logic [1:0] st, input logic [2:0] m);
        logic [15:0] r;
        r = 16'h0000;
        r[icc_pkg::CTRL_TMR_BIT] = ts;
        r[icc_pkg::CTRL_ICI_HI:icc_pkg::CTRL_ICI_LO] = ici;
        r[icc_pkg::CTRL_OV_BIT] = st[1];
        r[icc_pkg::CTRL_BNE_BIT] = st[0];
        r[icc_pkg::CTRL_MODE_HI -: 3] = m;
        return r;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] dv);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= dv;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    // read data sampled mid-cycle after the taking edge
    task automatic rd(input logic [5:0] a, output logic [15:0] dv);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(negedge clock_i);
        dv = rdata_o;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask

    // pin change with fresh random timer counts held over the detecting edge
    task automatic evt(input int c, input logic lvl);
        pins.set_level(c, lvl);
        l2 = xs();
        l3 = xs();
        t2 <= l2;
        t3 <= l3;
        @(posedge clock_i);
    endtask

    task automatic pulse(input int c, input logic ts);
        evt(c, 1'b1);
        q.push_back(ts ? l3 : l2);
        evt(c, 1'b0);
    endtask

    initial begin
        {addr_i, wdata_i, wr_i, rd_i, t2, t3, sleep_i, idle_i} = '0;
        srst_i = 1'b1;
        rng = 32'h00000033;
        {error_cnt, check_count, cycles, wakes} = '0;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        rchk(A_CTL, cw(1'b1, 2'h0, 2'h0, icc_pkg::MODE_OFF));
        rchk(A_FLG, 16'h0000);
        rchk(A_ENA, 16'h0000);
        rchk(6'h3F, 16'h0000);
        $display("test reset done");

        wr(A_CTL, cw(1'b1, 2'h0, 2'h0, icc_pkg::MODE_RISE));
        repeat (5) pulse(0, 1'b1);
        rchk(A_CTL, cw(1'b1, 2'h0, 2'h3, icc_pkg::MODE_RISE));
        chk({15'h0000, irq_o}, 16'h0000);
        for (int i = 0; i < 3; i++) rchk(A_BUF, q[i]);
        pulse(0, 1'b1);
        rchk(A_BUF, q[3]);
        rchk(A_CTL, cw(1'b1, 2'h0, 2'h2, icc_pkg::MODE_RISE));
        q.delete();
        pulse(0, 1'b1);
        rchk(A_BUF, q[0]);
        rchk(A_FLG, 16'h0001);
        rchk(A_FLG, 16'h0000);
        $display("test fifo done");

        for (int i = 0; i < 6; i++) begin
            w = xs();
            ch = int'(w[2:0]);
            q.delete();
            wr(A_CTL + 6'(ch), cw(w[3], 2'h0, 2'h0, icc_pkg::MODE_RISE));
            pulse(ch, w[3]);
            rchk(A_BUF + 6'(ch), q[0]);
            rchk(A_FLG, 16'h0001 << ch);
        end
        $display("test timer select done");

        wr(A_CTL, cw(1'b1, 2'h1, 2'h0, icc_pkg::MODE_RISE));
        pulse(0, 1'b1);
        rd(A_FLG, v);
        pulse(0, 1'b1);
        rd(A_FLG, w);
        pulse(0, 1'b1);
        rd(A_FLG, v);
        chk(v ^ w, 16'h0001);
        chk(w, 16'h0001);
        chk(v, 16'h0000);
        repeat (3) rd(A_BUF, v);
        $display("test event count done");

        wr(A_ENA, 16'h0001);
        wr(A_CTL, cw(1'b1, 2'h3, 2'h0, icc_pkg::MODE_EVERY_EDGE));
        q.delete();
        for (int i = 0; i < 6; i++) begin
            evt(0, ~pin[0]);
            q.push_back(l3);
            @(negedge clock_i);
            chk({15'h0000, irq_o}, 16'h0001);
            rchk(A_FLG, 16'h0001);
        end
        rchk(A_CTL, cw(1'b1, 2'h3, 2'h1, icc_pkg::MODE_EVERY_EDGE));
        for (int i = 0; i < 4; i++) rchk(A_BUF, q[i]);
        $display("test every edge done");

        wr(A_CTL, cw(1'b1, 2'h3, 2'h0, icc_pkg::MODE_INT_ONLY));
        @(posedge clock_i);
        sleep_i <= 1'b1;
        ch = wakes;
        pulse(0, 1'b1);
        repeat (2) @(posedge clock_i);
        chk(16'(wakes - ch), 16'h0001);
        rchk(A_FLG, 16'h0001);
        rchk(A_CTL, cw(1'b1, 2'h3, 2'h0, icc_pkg::MODE_INT_ONLY));
        wr(A_CTL, cw(1'b1, 2'h0, 2'h0, icc_pkg::MODE_RISE4));
        repeat (4) pulse(0, 1'b1);
        rchk(A_FLG, 16'h0000);
        $display("test sleep done");

        @(posedge clock_i);
        sleep_i <= 1'b0;
        idle_i  <= 1'b1;
        wr(A_CTL, cw(1'b1, 2'h0, 2'h0, icc_pkg::MODE_INT_ONLY));
        ch = wakes;
        pulse(0, 1'b1);
        repeat (2) @(posedge clock_i);
        chk(16'(wakes - ch), 16'h0001);
        rchk(A_FLG, 16'h0001);
        rchk(A_CTL, cw(1'b1, 2'h0, 2'h0, icc_pkg::MODE_INT_ONLY));
        for (int m = 0; m < 2; m++) begin
            md = (m == 1) ? icc_pkg::MODE_RISE16 : icc_pkg::MODE_RISE4;
            wr(A_CTL, cw(1'b1, 2'h0, 2'h0, md));
            q.delete();
            repeat ((m == 1) ? 16 : 4) pulse(0, 1'b1);
            rchk(A_CTL, cw(1'b1, 2'h0, 2'h1, md));
            rchk(A_BUF, q[(m == 1) ? 15 : 3]);
        end
        // stop-in-idle freezes the channel, falling edges stamped once awake
        wr(A_CTL, cw(1'b0, 2'h0, 2'h0, icc_pkg::MODE_FALL) | (16'h0001 << icc_pkg::CTRL_SIDL_BIT));
        pulse(0, 1'b0);
        rchk(A_CTL, cw(1'b0, 2'h0, 2'h0, icc_pkg::MODE_FALL) | (16'h0001 << icc_pkg::CTRL_SIDL_BIT));
        @(posedge clock_i);
        idle_i <= 1'b0;
        evt(0, 1'b1);
        evt(0, 1'b0);
        rchk(A_BUF, l2);
        $display("test idle done");
        final_report();
    end
endmodule
